// file: common/aspm_pkg.sv
package aspm_pkg;

  // ==========================================================================
  // Register map (byte addresses, one aligned word each)
  localparam logic [7:0] OFS_CONTROL = 8'h00;
  localparam logic [7:0] OFS_BUFFER  = 8'h04;
  localparam logic [7:0] OFS_POWER   = 8'h08;
  localparam logic [7:0] OFS_SLV_ADDR = 8'h0C;
  localparam logic [7:0] OFS_SLV_MASK = 8'h10;

  // ==========================================================================
  // Field positions
  localparam int unsigned PWR_BAUD_DOUBLER = 7;
  localparam int unsigned PWR_ERR_VIEW     = 6;

  // ==========================================================================
  // Reset values
  localparam logic [7:0] CONTROL_RST = 8'h00;
  localparam logic [7:0] ADDR_RST    = 8'h00;
  localparam logic [7:0] BUFFER_RST  = 8'h00;

  // ==========================================================================
  // Timing
  localparam logic [3:0] DIV_LAST      = 4'hF;
  localparam logic [3:0] SAMPLE_FIRST  = 4'h7;
  localparam logic [3:0] SAMPLE_SECOND = 4'h8;
  localparam logic [3:0] SAMPLE_THIRD  = 4'h9;
  localparam logic [3:0] FRAME_BITS_10 = 4'hA;
  localparam logic [3:0] FRAME_BITS_11 = 4'hB;
  localparam logic [1:0] OSC_SLOW_LAST = 2'h3;

  // ==========================================================================
  // Types
  typedef enum logic [1:0] {
    MODE_SYNC8         = 2'b00,
    MODE_ASYNC10       = 2'b01,
    MODE_ASYNC11_FIXED = 2'b10,
    MODE_ASYNC11_TIMER = 2'b11
  } aspm_mode_t;

  typedef enum logic [0:0] {
    RX_IDLE = 1'b0,
    RX_BITS = 1'b1
  } aspm_rx_state_t;

  typedef struct packed {
    logic modeBitUpper;
    logic modeBitLower;
    logic multiprocSelect;
    logic rxEnable;
    logic txNinthBit;
    logic rxNinthBit;
    logic txDoneFlag;
    logic rxDoneFlag;
  } aspm_control_t;

endpackage

// file: hdl/aspm_serial_port.sv
// The register offsets and the APB register port were chosen for this implementation.
`timescale 1ns/1ns
// Function
// RULE1 - Ten-bit frame: start, 8 data LSB first, stop
// RULE2 - Ten-bit mode stores stop bit in rx ninth
// RULE3 - Ten-bit rate: timer overflow over 16 or 32
// RULE4 - Buffer write starts tx; bits on rollovers
// RULE5 - Ten-bit tx done at tenth rollover
// RULE6 - Receive only with enable; starts on fall
// RULE7 - Sample at 16x rate; edge resets divider
// RULE8 - Bit value: majority of states 8,9,10; code votes on divider values 7,8,9
// RULE9 - Nonzero start bit aborts, rehunt falling edge
// RULE10 - Load only if done clear and select allows
// RULE11 - After mid stop, hunt next falling edge
// RULE12 - Eleven-bit frame carries programmable ninth bit
// RULE13 - Fixed mode: oscillator over 32 or 64
// RULE14 - Eleven-bit tx done at eleventh rollover
// RULE15 - Timer eleven-bit mode same, timer rate
// RULE16 - Two-bit field selects one of four modes
// RULE17 - Far device starts transfer with start bit
// RULE18 - Missing stop bit sets frame error
// RULE19 - Control bit 7 view chosen by power bit 6
// RULE20 - Frame error: hardware sets, software clears
// RULE21 - Select set: done only on address match
// RULE22 - Mask bits choose compared address bits
// RULE23 - Done flags held until software clears
module aspm_serial_port
  import aspm_pkg::*;
(
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        sys_rst,
  // APB slave
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Baud source
  input  wire logic        timerOverflow,
  // Serial lines
  input  wire logic        rxLine,
  output logic             txLine
);

  // ==========================================================================
  // Register state
  aspm_control_t  ctl_q;
  aspm_rx_state_t rxState_q;
  logic       baudDoubler_q;
  logic       errView_q;
  logic       errFlag_q;
  logic [7:0] rxBuf_q;
  logic [7:0] slaveAddr_q;
  logic [7:0] slaveMask_q;
  logic [31:0] prdata_q;

  logic [1:0] oscCnt_q;
  logic       timerHalf_q;
  logic [3:0] divCnt_q;
  logic [10:0] txShift_q;
  logic [3:0] txCnt_q;
  logic       txBusy_q;
  logic       txLine_q;
  logic       rxPrev_q;
  logic [3:0] rxBitCnt_q;
  logic [8:0] rxShift_q;
  logic       sampleA_q;
  logic       sampleB_q;
  logic [3:0] rollCnt_q;

  function automatic logic isMapped(input logic [7:0] a);
    return a == OFS_CONTROL || a == OFS_BUFFER || a == OFS_POWER ||
           a == OFS_SLV_ADDR || a == OFS_SLV_MASK;
  endfunction

  // ==========================================================================
  // Mode and bus decode
  aspm_mode_t mode;
  logic       asyncMode;
  logic       tenBit;
  logic [3:0] frameBits;
  logic       wrEn;
  logic       wrCtl;
  logic       wrBuf;

  assign mode      = aspm_mode_t'({ctl_q.modeBitUpper,
                                   ctl_q.modeBitLower}); // RULE16
  assign asyncMode = mode != MODE_SYNC8;
  assign tenBit    = mode == MODE_ASYNC10;
  assign frameBits = tenBit ? FRAME_BITS_10 : FRAME_BITS_11;
  assign wrEn      = psel && penable && pwrite;
  assign wrCtl     = wrEn && paddr == OFS_CONTROL;
  assign wrBuf     = wrEn && paddr == OFS_BUFFER;

  // ==========================================================================
  // Sixteen-times bit rate tick
  logic oscTick;
  logic timerTick;
  logic tick;

  assign oscTick   = baudDoubler_q ? oscCnt_q[0]
                                   : oscCnt_q == OSC_SLOW_LAST; // RULE13
  assign timerTick = timerOverflow && (baudDoubler_q || timerHalf_q); // RULE3
  // Timer mode of eleven-bit frames differs only in its tick source
  assign tick      = asyncMode &&
                     (mode == MODE_ASYNC11_FIXED ? oscTick
                                                 : timerTick); // RULE15

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      oscCnt_q    <= 2'h0;
      timerHalf_q <= 1'b0;
    end
    else
    begin
      oscCnt_q <= oscCnt_q + 2'h1;
      if (timerOverflow)
        timerHalf_q <= !timerHalf_q;
    end
  end

  // ==========================================================================
  // Shared divide-by-16 counter, realigned by a received falling edge
  logic fallEdge;
  logic rxStart;
  logic txRoll;

  assign fallEdge = tick && rxPrev_q && !rxLine; // RULE7
  assign rxStart  = rxState_q == RX_IDLE && fallEdge && ctl_q.rxEnable; // RULE6
  assign txRoll   = tick && divCnt_q == DIV_LAST;

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      divCnt_q <= 4'h0;
      rxPrev_q <= 1'b1;
    end
    else
    begin
      if (tick)
        rxPrev_q <= rxLine; // RULE7
      if (rxStart)
        divCnt_q <= 4'h0; // RULE7
      else if (tick)
        divCnt_q <= divCnt_q + 4'h1;
    end
  end

  // ==========================================================================
  // Transmitter
  logic txDoneSet;

  assign txDoneSet = txBusy_q && txRoll &&
                     txCnt_q == frameBits - 4'h1; // RULE5 RULE14

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      txShift_q <= 11'h7FF;
      txCnt_q   <= 4'h0;
      txBusy_q  <= 1'b0;
      txLine_q  <= 1'b1;
    end
    else if (wrBuf && asyncMode)
    begin
      // A write during a frame restarts it; software should wait for done
      txShift_q <= {1'b1, tenBit ? 1'b1 : ctl_q.txNinthBit,
                    pwdata[7:0], 1'b0}; // RULE1 RULE12
      txCnt_q   <= 4'h0;
      txBusy_q  <= 1'b1; // RULE4
    end
    else if (txBusy_q && txRoll)
    begin
      txLine_q  <= txShift_q[0]; // RULE4
      txShift_q <= {1'b1, txShift_q[10:1]};
      txCnt_q   <= txCnt_q + 4'h1;
      if (txDoneSet)
        txBusy_q <= 1'b0;
    end
  end

  assign txLine = txLine_q;

  // ==========================================================================
  // Receiver
  logic       decide;
  logic       vote;
  logic       frameEnd;
  logic [7:0] rxData;
  logic       rxNinth;
  logic       addrBit;
  logic       addrMatch;
  logic       rxLoad;

  assign decide = rxState_q == RX_BITS && tick && divCnt_q == SAMPLE_THIRD;
  assign vote   = (sampleA_q && sampleB_q) || (sampleA_q && rxLine) ||
                  (sampleB_q && rxLine); // RULE8
  assign frameEnd = decide && rxBitCnt_q == frameBits - 4'h1;
  assign rxData   = tenBit ? rxShift_q[8:1] : rxShift_q[7:0];
  assign rxNinth  = tenBit ? vote : rxShift_q[8]; // RULE2 RULE12
  assign addrBit  = tenBit ? vote : rxShift_q[8];
  // Given address through the mask, broadcast through the or of both
  assign addrMatch =
    ((rxData ^ slaveAddr_q) & slaveMask_q) == 8'h00 ||
    (~rxData & (slaveAddr_q | slaveMask_q)) == 8'h00; // RULE22
  assign rxLoad = frameEnd && !ctl_q.rxDoneFlag &&
                  (!ctl_q.multiprocSelect ||
                   (addrBit && addrMatch)); // RULE10 RULE21

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      rxState_q  <= RX_IDLE;
      rxBitCnt_q <= 4'h0;
      rxShift_q  <= 9'h000;
      sampleA_q  <= 1'b1;
      sampleB_q  <= 1'b1;
    end
    else
    begin
      if (rxState_q == RX_BITS && tick && divCnt_q == SAMPLE_FIRST)
        sampleA_q <= rxLine; // RULE8
      if (rxState_q == RX_BITS && tick && divCnt_q == SAMPLE_SECOND)
        sampleB_q <= rxLine; // RULE8
      unique case (rxState_q)
        RX_IDLE:
        begin
          if (rxStart)
          begin
            rxState_q  <= RX_BITS;
            rxBitCnt_q <= 4'h0;
          end
        end
        RX_BITS:
        begin
          if (!asyncMode)
            rxState_q <= RX_IDLE;
          else if (decide)
          begin
            if (rxBitCnt_q == 4'h0 && vote)
              rxState_q <= RX_IDLE; // RULE9
            else if (frameEnd)
              rxState_q <= RX_IDLE; // RULE11
            else
            begin
              if (rxBitCnt_q != 4'h0)
                rxShift_q <= {vote, rxShift_q[8:1]};
              rxBitCnt_q <= rxBitCnt_q + 4'h1;
            end
          end
        end
      endcase
    end
  end

  // ==========================================================================
  // Software registers
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      ctl_q <= aspm_control_t'(CONTROL_RST);
    else
    begin
      if (wrCtl)
      begin
        if (!errView_q)
          ctl_q.modeBitUpper <= pwdata[7]; // RULE19
        ctl_q.modeBitLower    <= pwdata[6];
        ctl_q.multiprocSelect <= pwdata[5];
        ctl_q.rxEnable        <= pwdata[4];
        ctl_q.txNinthBit      <= pwdata[3];
        ctl_q.rxNinthBit      <= pwdata[2];
        ctl_q.txDoneFlag      <= pwdata[1];
        ctl_q.rxDoneFlag      <= pwdata[0];
      end
      // Hardware set beats a software clear in the same cycle
      if (txDoneSet)
        ctl_q.txDoneFlag <= 1'b1; // RULE23
      if (rxLoad)
      begin
        ctl_q.rxDoneFlag <= 1'b1; // RULE23
        ctl_q.rxNinthBit <= rxNinth; // RULE2
      end
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      errFlag_q <= 1'b0;
    else if (frameEnd && !vote)
      errFlag_q <= 1'b1; // RULE18
    else if (wrCtl && errView_q && !pwdata[7])
      errFlag_q <= 1'b0; // RULE20
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      rxBuf_q <= BUFFER_RST;
    else if (rxLoad)
      rxBuf_q <= rxData; // RULE10
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      baudDoubler_q <= 1'b0;
      errView_q     <= 1'b0;
      slaveAddr_q   <= ADDR_RST;
      slaveMask_q   <= ADDR_RST;
    end
    else if (wrEn)
    begin
      if (paddr == OFS_POWER)
      begin
        baudDoubler_q <= pwdata[PWR_BAUD_DOUBLER];
        errView_q     <= pwdata[PWR_ERR_VIEW];
      end
      if (paddr == OFS_SLV_ADDR)
        slaveAddr_q <= pwdata[7:0];
      if (paddr == OFS_SLV_MASK)
        slaveMask_q <= pwdata[7:0];
    end
  end

  // ==========================================================================
  // Read data is latched in the setup cycle; zero wait states
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      prdata_q <= 32'h0000_0000;
    else if (psel && !penable && !pwrite)
    begin
      unique case (paddr)
        OFS_CONTROL: prdata_q <= {24'h000000,
          errView_q ? errFlag_q : ctl_q.modeBitUpper, // RULE19
          ctl_q.modeBitLower, ctl_q.multiprocSelect, ctl_q.rxEnable,
          ctl_q.txNinthBit, ctl_q.rxNinthBit, ctl_q.txDoneFlag,
          ctl_q.rxDoneFlag};
        OFS_BUFFER:  prdata_q <= {24'h000000, rxBuf_q};
        OFS_POWER:   prdata_q <= {24'h000000, baudDoubler_q, errView_q,
                                  6'h00};
        OFS_SLV_ADDR: prdata_q <= {24'h000000, slaveAddr_q};
        OFS_SLV_MASK: prdata_q <= {24'h000000, slaveMask_q};
        default:     prdata_q <= 32'h0000_0000;
      endcase
    end
  end

  assign prdata  = prdata_q;
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !isMapped(paddr);

  // ==========================================================================
  // Checks
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      rollCnt_q <= 4'h0;
    else if (wrBuf && asyncMode)
      rollCnt_q <= 4'h0;
    else if (txBusy_q && txRoll)
      rollCnt_q <= rollCnt_q + 4'h1;
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  sequence s_tx_first_roll;
    txBusy_q && txRoll && txCnt_q == 4'h0 && !wrBuf;
  endsequence

  sequence s_rx_bad_start;
    decide && rxBitCnt_q == 4'h0 && vote && asyncMode;
  endsequence

  a_tx_start_bit: assert property ( // RULE4
    s_tx_first_roll |=> !txLine_q ##0 txBusy_q)
    else $error("start bit not driven at first rollover");

  a_tx_done_roll: assert property ( // RULE5
    $rose(ctl_q.txDoneFlag) && !$past(wrCtl) |-> rollCnt_q == frameBits)
    else $error("transmit done at wrong rollover");

  a_rx_abort_bad: assert property ( // RULE9
    s_rx_bad_start |=> rxState_q == RX_IDLE ##1 !rxLoad)
    else $error("bad start bit did not abort");

  a_rx_needs_en: assert property ( // RULE6
    rxState_q == RX_IDLE && !ctl_q.rxEnable |=> rxState_q == RX_IDLE)
    else $error("receiver started while disabled");

  a_edge_resets_div: assert property ( // RULE7
    rxStart && asyncMode |=> divCnt_q == 4'h0 && rxState_q == RX_BITS)
    else $error("falling edge did not realign divider");

  a_rx_buf_held: assert property ( // RULE10
    ctl_q.rxDoneFlag |=> $stable(rxBuf_q))
    else $error("receive buffer overwritten while done set");

  a_err_sticky: assert property ( // RULE20
    errFlag_q && !(wrCtl && errView_q) |=> errFlag_q)
    else $error("frame error cleared without software");

  a_err_on_bad_stop: assert property ( // RULE18
    frameEnd && !vote |=> errFlag_q)
    else $error("bad stop bit did not flag frame error");

  a_flags_hold: assert property ( // RULE23
    ctl_q.txDoneFlag && !wrCtl |=> ctl_q.txDoneFlag)
    else $error("transmit done cleared by hardware");

  a_mode_view: assert property ( // RULE19
    wrCtl && errView_q |=> $stable(ctl_q.modeBitUpper))
    else $error("upper mode bit changed through error view");

endmodule // aspm_serial_port

// file: bench/aspm_serial_peer.sv
`timescale 1ns/1ns
module aspm_serial_peer
(
  // Clock
  input  wire logic sysClk,
  // Serial lines
  input  wire logic txLine,
  output logic      rxLine
);
  // ======
  // Sender, line idles high
  initial rxLine = 1'b1;

  task automatic sendFrame(input logic [10:0] bits, input int n,
                           input int bitClks);
    for (int i = 0; i < n; i++)
    begin
      @(posedge sysClk) rxLine <= bits[i];
      repeat (bitClks - 1) @(posedge sysClk);
    end
    @(posedge sysClk) rxLine <= 1'b1;
  endtask

  // Too short to survive the start bit vote
  task automatic glitch(input int lowClks);
    @(posedge sysClk) rxLine <= 1'b0;
    repeat (lowClks) @(posedge sysClk);
    rxLine <= 1'b1;
  endtask

  // ======
  // Receiver, samples mid-bit so a wrong rate corrupts the data
  task automatic getFrame(output logic [10:0] bits, input int n,
                          input int bitClks, output bit ok);
    int w;
    bits = '1;
    w = 0;
    while (txLine !== 1'b0 && w < 4000)
    begin
      @(posedge sysClk);
      w++;
    end
    ok = (w < 4000);
    repeat (bitClks / 2) @(posedge sysClk);
    for (int i = 0; i < n; i++)
    begin
      bits[i] = txLine;
      repeat (bitClks) @(posedge sysClk);
    end
  endtask
endmodule // aspm_serial_peer

// file: bench/aspm_serial_port_test.sv
`timescale 1ns/1ns
module aspm_serial_port_test
  import aspm_pkg::*;
;
  logic        sysClk        = 1'b0;
  logic        sysRst        = 1'b1;
  logic [7:0]  paddr         = 8'h00;
  logic        psel          = 1'b0;
  logic        penable       = 1'b0;
  logic        pwrite        = 1'b0;
  logic [31:0] pwdata        = 32'h0;
  logic        timerOverflow = 1'b0;
  logic [1:0]  ovfCnt        = 2'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        rxLine;
  logic        txLine;
  int          err_count     = 0;
  int          checked       = 0;
  logic [7:0]  ctlTab [4]    = '{8'h50, 8'h98, 8'h90, 8'hD8};
  logic [7:0]  pwrTab [4]    = '{8'h80, 8'h80, 8'h00, 8'h00};
  int          bcTab  [4]    = '{48, 32, 64, 96};
  int          nTab   [4]    = '{10, 11, 11, 11};

  always #25 sysClk = ~sysClk;

  // Timer overflow every third clock
  always @(posedge sysClk)
  begin
    ovfCnt <= (ovfCnt == 2'h2) ? 2'h0 : ovfCnt + 2'h1;
    timerOverflow <= (ovfCnt == 2'h2);
  end

  aspm_serial_port dut
  (
    .sys_clk       (sysClk),
    .sys_rst       (sysRst),
    .paddr         (paddr),
    .psel          (psel),
    .penable       (penable),
    .pwrite        (pwrite),
    .pwdata        (pwdata),
    .prdata        (prdata),
    .pready        (pready),
    .pslverr       (pslverr),
    .timerOverflow (timerOverflow),
    .rxLine        (rxLine),
    .txLine        (txLine)
  );

  aspm_serial_peer peer
  (
    .sysClk (sysClk),
    .txLine (txLine),
    .rxLine (rxLine)
  );

  // ======
  // Reporting
  task automatic test_done;
    if (err_count == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      err_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // ======
  // APB master
  task automatic apb(input logic [7:0] a, input logic wr,
                     input logic [7:0] d, output logic [31:0] rd,
                     output logic se);
    int n;
    n = 0;
    @(posedge sysClk);
    paddr <= a;
    pwrite <= wr;
    pwdata <= {24'h0, d};
    psel <= 1'b1;
    @(posedge sysClk);
    penable <= 1'b1;
    do
    begin
      @(posedge sysClk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    rd = prdata;
    se = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20)
    begin
      err_count++;
      test_done;
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] r;
    logic        e;
    apb(a, 1'b1, d, r, e);
  endtask

  task automatic rdChk(input logic [7:0] a, input logic [7:0] exp);
    logic [31:0] r;
    logic        e;
    apb(a, 1'b0, 8'h00, r, e);
    check(r, {24'h0, exp});
  endtask

  task automatic txChk(input logic [7:0] d, input logic nb, input int n,
                       input int bc);
    logic [10:0] got;
    bit          ok;
    wr(OFS_BUFFER, d);
    peer.getFrame(got, n, bc, ok);
    if (!ok)
    begin
      err_count++;
      test_done;
    end
    check({21'h0, got}, {21'h0, 1'b1, nb, d, 1'b0});
  endtask

  // ======
  // Main sequence
  initial
  begin
    logic [31:0] r;
    logic        e;
    logic        rb;
    repeat (10) @(posedge sysClk);
    sysRst <= 1'b0;
    rdChk(OFS_CONTROL, CONTROL_RST);
    rdChk(OFS_POWER, 8'h00);
    rdChk(OFS_SLV_ADDR, ADDR_RST);
    rdChk(OFS_SLV_MASK, ADDR_RST);
    apb(8'h14, 1'b0, 8'h00, r, e);
    check({31'h0, e}, 32'h1);
    check(r, 32'h0);
    wr(OFS_BUFFER, 8'h55);
    repeat (200) @(posedge sysClk);
    check({31'h0, txLine}, 32'h1);
    for (int i = 0; i < 4; i++)
    begin
      rb = (i != 2);
      wr(OFS_POWER, pwrTab[i]);
      wr(OFS_CONTROL, ctlTab[i]);
      txChk(8'hA5 ^ i[7:0], ctlTab[i][3] | (i == 0), nTab[i],
            bcTab[i]);
      rdChk(OFS_CONTROL, ctlTab[i] | 8'h02);
      peer.sendFrame({1'b1, rb, 8'h3C + i[7:0], 1'b0}, nTab[i], bcTab[i]);
      rdChk(OFS_BUFFER, 8'h3C + i[7:0]);
      rdChk(OFS_CONTROL, ctlTab[i] | 8'h03 | {5'h0, rb, 2'h0});
    end
    wr(OFS_POWER, 8'h80);
    wr(OFS_CONTROL, 8'h90);
    peer.sendFrame({2'b10, 8'h11, 1'b0}, 11, 32);
    peer.sendFrame({2'b10, 8'h22, 1'b0}, 11, 32);
    rdChk(OFS_BUFFER, 8'h11);
    rdChk(OFS_CONTROL, 8'h91);
    wr(OFS_CONTROL, 8'h90);
    peer.glitch(4);
    repeat (40) @(posedge sysClk);
    peer.sendFrame({2'b11, 8'h5A, 1'b0}, 11, 32);
    rdChk(OFS_BUFFER, 8'h5A);
    rdChk(OFS_CONTROL, 8'h95);
    wr(OFS_CONTROL, 8'h90);
    wr(OFS_POWER, 8'hC0);
    rdChk(OFS_CONTROL, 8'h10);
    peer.sendFrame({2'b00, 8'h66, 1'b0}, 11, 32);
    rdChk(OFS_CONTROL, 8'h91);
    wr(OFS_CONTROL, 8'h90);
    peer.sendFrame({2'b10, 8'h77, 1'b0}, 11, 32);
    rdChk(OFS_CONTROL, 8'h91);
    wr(OFS_CONTROL, 8'h10);
    rdChk(OFS_CONTROL, 8'h10);
    wr(OFS_POWER, 8'h80);
    rdChk(OFS_CONTROL, 8'h90);
    wr(OFS_SLV_ADDR, 8'hA4);
    wr(OFS_SLV_MASK, 8'hFA);
    rdChk(OFS_SLV_MASK, 8'hFA);
    wr(OFS_CONTROL, 8'hB0);
    peer.sendFrame({2'b11, 8'hA3, 1'b0}, 11, 32);
    peer.sendFrame({2'b10, 8'hA0, 1'b0}, 11, 32);
    rdChk(OFS_CONTROL, 8'hB0);
    peer.sendFrame({2'b11, 8'hA0, 1'b0}, 11, 32);
    rdChk(OFS_BUFFER, 8'hA0);
    rdChk(OFS_CONTROL, 8'hB5);
    wr(OFS_CONTROL, 8'hB0);
    peer.sendFrame({2'b11, 8'hFE, 1'b0}, 11, 32);
    rdChk(OFS_BUFFER, 8'hFE);
    test_done;
  end
endmodule // aspm_serial_port_test
